// [pkg/adc_scan_pkg.sv]
// Purpose: shared constants and types for the scan and trigger control block
// Assumes: APB register access, 32-bit words, eight analog channels plus one diagnostic slot
// Notes: register layouts are packed structs so a bus write maps straight onto fields
package adc_scan_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHAN_A = 8'h04;
  localparam logic [7:0] OFF_CHAN_B = 8'h08;
  localparam logic [7:0] OFF_TRIG = 8'h0C;
  localparam logic [7:0] OFF_CONF = 8'h10;
  localparam logic [7:0] OFF_CMP = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [7:0] OFF_DUP = 8'h1C;
  localparam logic [7:0] OFF_DATA = 8'h20;
  localparam logic [7:0] OFF_DIAG = 8'h40;
  // ****************************************
  // positions, sizes and reset values
  // ****************************************
  localparam int unsigned NUM_CH = 8;
  localparam logic [3:0] DIAG_CH = 4'h8;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam logic [3:0] TRIG_SEL_EVENT_LINK = 4'hF;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_CHAN = 32'h0000_0000;
  localparam logic [31:0] RST_TRIG = 32'h0000_0000;
  localparam logic [31:0] RST_CONF = 32'h0000_0000;
  localparam logic [31:0] RST_CMP = 32'h0000_0000;
  localparam logic [13:0] RST_DATA = 14'h0000;
  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {SCAN_SINGLE, SCAN_CONT, SCAN_GROUP, SCAN_RSVD} scan_mode_type;
  typedef enum logic [1:0] {CMP_OFF, CMP_ABOVE, CMP_BELOW, CMP_PAIR} cmp_mode_type;
  typedef enum logic [1:0] {PREC_12, PREC_10, PREC_8, PREC_RSVD} prec_type;
  // ****************************************
  // register layouts
  // ****************************************
  typedef struct packed {
    logic [16:0] rsvd;
    logic module_stop;
    logic cmp_ie;
    logic gb_ie;
    logic scan_ie;
    logic [2:0] dbl_ch;
    logic dbl_en;
    logic rescan_en;
    logic a_priority;
    logic ext_sel;
    logic trig_en;
    scan_mode_type scan_mode;
    logic start;
  } ctrl_type;
  typedef struct packed {
    logic [23:0] rsvd;
    logic [3:0] sel_b;
    logic [3:0] sel_a;
  } trig_type;
  typedef struct packed {
    logic [1:0] rsvd;
    logic [2:0] sh_dedicated;
    logic [7:0] sample_states;
    logic [7:0] add_mask;
    logic [1:0] diag_val;
    logic diag_en;
    logic precharge;
    logic discharge;
    logic avg_en;
    logic [1:0] add_times;
    logic auto_clear;
    prec_type prec;
  } conf_type;
  typedef struct packed {
    logic [11:0] rsvd;
    logic [2:0] ch2;
    logic [2:0] ch;
    cmp_mode_type mode;
    logic [11:0] ref_val;
  } cmp_type;
  // ****************************************
  // analog core link
  // ****************************************
  typedef struct packed {
    logic start;
    logic abort;
    logic [3:0] ch;
    logic [7:0] sample_states;
    prec_type prec;
    logic precharge;
    logic discharge;
    logic [2:0] sh_dedicated;
    logic diag;
    logic [1:0] diag_val;
  } conv_req_type;
  typedef struct packed {
    logic done;
    logic [11:0] result;
  } conv_rsp_type;
endpackage : adc_scan_pkg

// [design/adc_scan_trigger_control.sv]
// Purpose: scan sequencing, trigger selection and event generation for a 12-bit converter
// Assumes: one clock mclk, synchronous active-low reset, core answers a start with done later
// Notes: all outputs registered; interrupt and event outputs are one-cycle pulses
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module adc_scan_trigger_control (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources
  input wire logic [14:0] sync_trig,
  input wire logic event_link_trig,
  input wire logic ext_trigger_n_unit_zero,
  // analog core
  output adc_scan_pkg::conv_req_type conv_req,
  input wire adc_scan_pkg::conv_rsp_type conv_rsp,
  // interrupt, transfer and event fabric
  output logic scan_end_irq,
  output logic group_b_scan_end_irq,
  output logic compare_match_irq,
  output logic dma_req,
  output logic event_link_out,
  output logic module_stopped
);
  import adc_scan_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_type;

  // ****************************************
  // helpers
  // ****************************************
  // lowest set bit gives ascending channel order
  function automatic logic [3:0] lowest(input logic [8:0] m);
    logic [3:0] r;
    r = DIAG_CH;
    for (int i = 8; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lowest

  // drop low bits for the coarser precisions
  function automatic logic [11:0] prec_fmt(input logic [11:0] v, input prec_type p);
    logic [11:0] r;
    r = v;
    if (p == PREC_10) begin
      r = {2'h0, v[11:2]};
    end else if (p == PREC_8) begin
      r = {4'h0, v[11:4]};
    end
    return r;
  endfunction : prec_fmt

  function automatic logic [8:0] onehot(input logic [3:0] c);
    return 9'h001 << c;
  endfunction : onehot

  // ****************************************
  // state
  // ****************************************
  ctrl_type ctrl_q;
  trig_type trig_q;
  conf_type conf_q;
  cmp_type cmp_q;
  logic [7:0] chan_a_q;
  logic [7:0] chan_b_q;
  state_type state_q;
  logic grp_b_q;
  logic [8:0] mask_q;
  logic [3:0] ch_q;
  logic [1:0] rep_q;
  logic [13:0] acc_q;
  logic dbl_phase_q;
  logic b_pend_q;
  logic [13:0] data_q [NUM_CH];
  logic [13:0] dup_q;
  logic [11:0] diag_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic scan_irq_q;
  logic gb_irq_q;
  logic cmp_irq_q;
  logic dma_q;
  logic event_q;
  conv_req_type conv_req_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable & pready_q;
  wire logic hit_data = paddr[7:5] == OFF_DATA[7:5];
  wire logic [2:0] data_idx = paddr[4:2];
  wire logic mapped = hit_data | paddr == OFF_CTRL | paddr == OFF_CHAN_A
    | paddr == OFF_CHAN_B | paddr == OFF_TRIG | paddr == OFF_CONF | paddr == OFF_CMP
    | paddr == OFF_STAT | paddr == OFF_DUP | paddr == OFF_DIAG;
  wire logic wr = access & pwrite & mapped;
  wire logic wr_ctrl = wr & paddr == OFF_CTRL;
  wire logic rd_data = access & ~pwrite & hit_data;
  wire logic busy = state_q != ST_IDLE;
  wire logic [31:0] stat_word = {24'h0, b_pend_q, dbl_phase_q, grp_b_q, busy, ch_q};
  wire logic [31:0] rd_word =
    hit_data ? {18'h0, data_q[data_idx]} :
    paddr == OFF_CTRL ? {ctrl_q[31:1], busy} :
    paddr == OFF_CHAN_A ? {24'h0, chan_a_q} :
    paddr == OFF_CHAN_B ? {24'h0, chan_b_q} :
    paddr == OFF_TRIG ? 32'(trig_q) :
    paddr == OFF_CONF ? 32'(conf_q) :
    paddr == OFF_CMP ? 32'(cmp_q) :
    paddr == OFF_STAT ? stat_word :
    paddr == OFF_DUP ? {18'h0, dup_q} :
    paddr == OFF_DIAG ? {20'h0, diag_q} : 32'h0000_0000;

  // ****************************************
  // trigger selection
  // ****************************************
  // pin falls to start; read only after two synchroniser stages
  wire logic ext_fall = ext_s3_q & ~ext_s2_q;
  wire logic [15:0] trig_src = {event_link_trig, sync_trig};
  wire logic is_group = ctrl_q.scan_mode == SCAN_GROUP;
  wire logic sw_start = wr_ctrl & pwdata[CTRL_START_BIT];
  // writing the control word with start low halts a running scan
  wire logic sw_halt = wr_ctrl & ~pwdata[CTRL_START_BIT] & busy;
  wire logic hw_a = ctrl_q.ext_sel ? ext_fall : trig_src[trig_q.sel_a];
  wire logic start_a = sw_start | (ctrl_q.trig_en & hw_a);
  wire logic start_b = is_group & ctrl_q.trig_en & ~ctrl_q.ext_sel
    & trig_src[trig_q.sel_b];
  wire logic stop = ctrl_q.module_stop | sw_halt;

  // ****************************************
  // scan masks and datapath
  // ****************************************
  // double trigger narrows group A to the one chosen channel
  wire logic [7:0] sel_a = ctrl_q.dbl_en ? 8'(8'h01 << ctrl_q.dbl_ch) : chan_a_q;
  wire logic [8:0] mask_a = {conf_q.diag_en, sel_a};
  wire logic [8:0] mask_b = {1'b0, chan_b_q};
  wire logic preempt = is_group & ctrl_q.a_priority & grp_b_q & busy & start_a;
  wire logic [11:0] res_p = prec_fmt(conv_rsp.result, conf_q.prec);
  wire logic [13:0] sum = acc_q + {2'h0, res_p};
  wire logic add_ch = ch_q != DIAG_CH & conf_q.add_mask[ch_q[2:0]];
  wire logic [1:0] reps = add_ch ? conf_q.add_times : 2'h0;
  wire logic last_rep = rep_q == reps;
  // averaging only divides exactly for two or four samples
  wire logic [13:0] avg = conf_q.add_times == 2'h3 ? sum >> 2 :
    conf_q.add_times == 2'h1 ? sum >> 1 : sum;
  wire logic [13:0] final_val = add_ch & conf_q.avg_en ? avg : sum;
  wire logic done_ev = state_q == ST_WAIT & conv_rsp.done & ~stop & ~preempt;
  wire logic store = done_ev & last_rep;
  wire logic [8:0] rest = mask_q & ~onehot(ch_q);
  wire logic scan_done = store & rest == 9'h000;
  wire logic dbl_first = ctrl_q.dbl_en & ~grp_b_q & ~dbl_phase_q;
  wire logic to_dup = ctrl_q.dbl_en & ~grp_b_q & dbl_phase_q & ch_q != DIAG_CH;
  wire logic cont_again = ctrl_q.scan_mode == SCAN_CONT & ~ctrl_q.dbl_en;
  wire logic rescan = b_pend_q & is_group;
  // comparison against the reference or against another result register
  wire logic cmp_hit =
    cmp_q.mode == CMP_ABOVE ? final_val > {2'h0, cmp_q.ref_val} :
    cmp_q.mode == CMP_BELOW ? final_val < {2'h0, cmp_q.ref_val} :
    cmp_q.mode == CMP_PAIR ? ch_q[2:0] == cmp_q.ch2 & final_val > data_q[cmp_q.ch] :
    1'b0;

  // ****************************************
  // synchroniser for the trigger pin
  // ****************************************
  // third stage only feeds the edge detector
  always_ff @(posedge mclk) begin
    ext_s1_q <= ext_trigger_n_unit_zero;
    ext_s2_q <= ext_s1_q;
    ext_s3_q <= ext_s2_q;
  end

  // ****************************************
  // apb slave
  // ****************************************
  // answer one cycle after setup, so every access has one wait-free phase
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // configuration registers; reserved bits kept at zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q <= ctrl_type'(RST_CTRL);
      chan_a_q <= RST_CHAN[7:0];
      chan_b_q <= RST_CHAN[7:0];
      trig_q <= trig_type'(RST_TRIG);
      conf_q <= conf_type'(RST_CONF);
      cmp_q <= cmp_type'(RST_CMP);
    end else if (wr) begin
      if (paddr == OFF_CTRL) ctrl_q <= ctrl_type'({17'h0, pwdata[14:1], 1'b0});
      if (paddr == OFF_CHAN_A) chan_a_q <= pwdata[7:0];
      if (paddr == OFF_CHAN_B) chan_b_q <= pwdata[7:0];
      if (paddr == OFF_TRIG) trig_q <= trig_type'({24'h0, pwdata[7:0]});
      if (paddr == OFF_CONF) conf_q <= conf_type'({2'h0, pwdata[29:0]});
      if (paddr == OFF_CMP) cmp_q <= cmp_type'({12'h0, pwdata[19:0]});
    end
  end

  // ****************************************
  // scan sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      grp_b_q <= 1'b0;
      mask_q <= 9'h000;
      ch_q <= 4'h0;
      rep_q <= 2'h0;
      acc_q <= 14'h0000;
      dbl_phase_q <= 1'b0;
      b_pend_q <= 1'b0;
    end else if (stop) begin
      state_q <= ST_IDLE;
      b_pend_q <= 1'b0;
    end else if (preempt) begin
      grp_b_q <= 1'b0;
      mask_q <= mask_a;
      ch_q <= lowest(mask_a);
      rep_q <= 2'h0;
      acc_q <= 14'h0000;
      b_pend_q <= ctrl_q.rescan_en;
      state_q <= ST_ISSUE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_a & |mask_a) begin
            grp_b_q <= 1'b0;
            mask_q <= mask_a;
            ch_q <= lowest(mask_a);
            state_q <= ST_ISSUE;
          end else if ((start_b | rescan) & |mask_b) begin
            grp_b_q <= 1'b1;
            b_pend_q <= 1'b0;
            mask_q <= mask_b;
            ch_q <= lowest(mask_b);
            state_q <= ST_ISSUE;
          end
          rep_q <= 2'h0;
          acc_q <= 14'h0000;
        end
        ST_ISSUE: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (done_ev & ~last_rep) begin
            rep_q <= rep_q + 2'h1;
            acc_q <= sum;
            state_q <= ST_ISSUE;
          end else if (store & ~scan_done) begin
            mask_q <= rest;
            ch_q <= lowest(rest);
            rep_q <= 2'h0;
            acc_q <= 14'h0000;
            state_q <= ST_ISSUE;
          end else if (scan_done) begin
            if (~grp_b_q & ctrl_q.dbl_en) begin
              dbl_phase_q <= ~dbl_phase_q;
            end
            rep_q <= 2'h0;
            acc_q <= 14'h0000;
            mask_q <= mask_a;
            ch_q <= lowest(mask_a);
            state_q <= cont_again ? ST_ISSUE : ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // result registers
  // ****************************************
  // a store in the cycle of a clearing read wins, so no result is lost
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        data_q[i] <= RST_DATA;
      end
      dup_q <= RST_DATA;
      diag_q <= RST_DATA[11:0];
    end else begin
      if (rd_data & conf_q.auto_clear) begin
        data_q[data_idx] <= RST_DATA;
      end
      if (store) begin
        if (ch_q == DIAG_CH) begin
          diag_q <= final_val[11:0];
        end else if (to_dup) begin
          dup_q <= final_val;
        end else begin
          data_q[ch_q[2:0]] <= final_val;
        end
      end
    end
  end

  // ****************************************
  // interrupt and event pulses
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scan_irq_q <= 1'b0;
      gb_irq_q <= 1'b0;
      cmp_irq_q <= 1'b0;
      dma_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      // single and continuous scans, second of a double pair, or group A scans
      scan_irq_q <= scan_done & ~grp_b_q & ~dbl_first & ctrl_q.scan_ie;
      gb_irq_q <= scan_done & grp_b_q & ctrl_q.gb_ie;
      cmp_irq_q <= store & ch_q != DIAG_CH & cmp_hit & ctrl_q.cmp_ie;
      dma_q <= scan_done & (grp_b_q ? ctrl_q.gb_ie
        : ~dbl_first & ctrl_q.scan_ie);
      event_q <= scan_done & ~grp_b_q;
    end
  end

  // ****************************************
  // analog core request
  // ****************************************
  // start pulses in the first wait cycle; the core must not answer in that cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      conv_req_q <= '0;
    end else begin
      conv_req_q.start <= state_q == ST_ISSUE & ~stop & ~preempt;
      conv_req_q.abort <= busy & (stop | preempt);
      conv_req_q.ch <= ch_q;
      conv_req_q.sample_states <= conf_q.sample_states;
      conv_req_q.sh_dedicated <= conf_q.sh_dedicated;
      conv_req_q.prec <= conf_q.prec;
      conv_req_q.precharge <= conf_q.precharge;
      conv_req_q.discharge <= conf_q.discharge & ~conf_q.precharge;
      conv_req_q.diag <= ch_q == DIAG_CH;
      conv_req_q.diag_val <= conf_q.diag_val;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_req = conv_req_q;
  assign scan_end_irq = scan_irq_q;
  assign group_b_scan_end_irq = gb_irq_q;
  assign compare_match_irq = cmp_irq_q;
  assign dma_req = dma_q;
  assign event_link_out = event_q;
  assign module_stopped = ctrl_q.module_stop;
endmodule : adc_scan_trigger_control
`default_nettype wire

// [bench/adc_scan_properties.sv]
// Purpose: port-level timing checks for the scan and trigger control block
// Assumes: one clock mclk, synchronous active-low rst_b
// Notes: every interrupt and event pulse is tied to the core answer one cycle earlier
`timescale 1ns/1ns
`default_nettype none
module adc_scan_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // analog core
  input wire adc_scan_pkg::conv_req_type conv_req,
  input wire adc_scan_pkg::conv_rsp_type conv_rsp,
  // pulses and status
  input wire logic scan_end_irq,
  input wire logic group_b_scan_end_irq,
  input wire logic compare_match_irq,
  input wire logic dma_req,
  input wire logic event_link_out,
  input wire logic module_stopped
);
  import adc_scan_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // pulse timing
  // ****************************************
  property p_irq_once; scan_end_irq |=> !scan_end_irq; endproperty
  a_irq_once: assert property (p_irq_once) else $error("scan end pulse too long");
  property p_irq_cause; scan_end_irq |-> $past(conv_rsp.done); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("scan end without done");
  property p_gb_cause; group_b_scan_end_irq |-> $past(conv_rsp.done); endproperty
  a_gb_cause: assert property (p_gb_cause) else $error("group b end without done");
  property p_cmp_cause; compare_match_irq |-> $past(conv_rsp.done); endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("compare without done");
  property p_dma; dma_req == (scan_end_irq || group_b_scan_end_irq); endproperty
  a_dma: assert property (p_dma) else $error("dma request mismatch");
  property p_gb_no_evt; group_b_scan_end_irq |-> !event_link_out; endproperty
  a_gb_no_evt: assert property (p_gb_no_evt) else $error("event on group b end");
  property p_evt_cause; event_link_out |-> $past(conv_rsp.done) ##1 !event_link_out; endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event pulse wrong");
  property p_stop; module_stopped && $past(module_stopped) |-> !conv_req.start; endproperty
  a_stop: assert property (p_stop) else $error("start while stopped");
  property p_one_out; conv_rsp.done |=> !conv_req.start; endproperty
  a_one_out: assert property (p_one_out) else $error("start too soon after done");
  property p_ready_pulse; pready |-> $past(psel && !penable); endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready without setup");
  // main scenarios reached
  c_gb: cover property (group_b_scan_end_irq);
  c_abort: cover property (conv_req.abort);
  c_cmp: cover property (compare_match_irq);
endmodule : adc_scan_properties
bind adc_scan_trigger_control adc_scan_properties chk (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .conv_req(conv_req), .conv_rsp(conv_rsp), .scan_end_irq(scan_end_irq),
  .group_b_scan_end_irq(group_b_scan_end_irq), .compare_match_irq(compare_match_irq),
  .dma_req(dma_req), .event_link_out(event_link_out), .module_stopped(module_stopped));
`default_nettype wire

// [bench/adc_core_model.sv]
// Purpose: behavioural analog core answering conversion starts
// Assumes: same clock as the control block
// Notes: result code is {channel, running sequence}; idle result scrambled
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // answer delay in cycles, at least 1
  input wire logic [7:0] lat,
  // core link
  input wire adc_scan_pkg::conv_req_type conv_req,
  output var adc_scan_pkg::conv_rsp_type conv_rsp
);
  import adc_scan_pkg::*;
  logic busy_q;
  logic [7:0] cnt_q;
  logic [3:0] ch_q;
  logic [7:0] seq_q;
  // one conversion at a time; an abort drops it unanswered
  always_ff @(posedge mclk) begin
    conv_rsp.done <= 1'b0;
    conv_rsp.result <= ~{ch_q, seq_q};  // never shows a stale valid code
    if (!rst_b) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      ch_q <= 4'h0;
      seq_q <= 8'h10;
    end else if (conv_req.abort) begin
      busy_q <= 1'b0;
    end else if (conv_req.start) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
      ch_q <= conv_req.ch;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q <= 8'h01) begin
        busy_q <= 1'b0;
        conv_rsp.done <= 1'b1;
        conv_rsp.result <= {ch_q, seq_q};
        seq_q <= seq_q + 8'h01;
      end
    end
  end
endmodule : adc_core_model
`default_nettype wire

// [bench/adc_scan_trigger_control_bench.sv]
// Purpose: self-checking bench for the scan and trigger control block
// Assumes: core model answers after a programmable delay
// Notes: expected data follow the model's {channel, sequence} result code
`timescale 1ns/1ns
`default_nettype none
module adc_scan_trigger_control_bench;
  import adc_scan_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, gb_irq, cmp_irq, dma, evt, stopped;
  logic [14:0] sync_trig = 15'h0000;
  logic event_link_trig = 1'b0;
  logic ext_n = 1'b1;
  logic [7:0] lat = 8'h03;
  conv_req_type conv_req;
  conv_rsp_type conv_rsp;
  int n_fail = 0;
  int num_checks = 0;
  int n_irq = 0, n_gb = 0, n_cmp = 0, n_dma = 0, n_evt = 0, n_abort = 0;
  always #2 mclk = ~mclk;
  adc_scan_trigger_control dut (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_trig(sync_trig), .event_link_trig(event_link_trig),
    .ext_trigger_n_unit_zero(ext_n), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .scan_end_irq(irq), .group_b_scan_end_irq(gb_irq), .compare_match_irq(cmp_irq),
    .dma_req(dma), .event_link_out(evt), .module_stopped(stopped));
  adc_core_model core (
    .mclk(mclk), .rst_b(rst_b), .lat(lat), .conv_req(conv_req), .conv_rsp(conv_rsp));
  // pulse tallies; an unknown pulse never counts
  always @(posedge mclk) begin
    if (rst_b) begin
      n_irq <= n_irq + (irq === 1'b1);
      n_gb <= n_gb + (gb_irq === 1'b1);
      n_cmp <= n_cmp + (cmp_irq === 1'b1);
      n_dma <= n_dma + (dma === 1'b1);
      n_evt <= n_evt + (evt === 1'b1);
      n_abort <= n_abort + (conv_req.abort === 1'b1);
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer; an idle cycle follows so drivers never clash
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no limit of its own: the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q);
  endtask : rd
  // poll busy and pending rescan; an unknown status keeps polling until the watchdog
  task automatic wait_idle();
    logic [31:0] q;
    logic e;
    repeat (8) @(posedge mclk);
    do begin
      apb(1'b0, OFF_STAT, 32'h0, q, e);
    end while ((q & 32'h90) !== 32'h0);
  endtask : wait_idle
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    logic [31:0] q;
    logic e;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd("ctrl_reset", OFF_CTRL, RST_CTRL);
    rd("conf_reset", OFF_CONF, RST_CONF);
    apb(1'b0, 8'h44, 32'h0, q, e);
    chk("unmapped_data", 32'h0, q);
    chk("unmapped_err", 32'h1, {31'h0, e});
    // single scan of ch0 and ch2, compare each result above 0x100
    wr(OFF_CMP, 32'h0000_9100);
    wr(OFF_CHAN_A, 32'h05);
    wr(OFF_CTRL, 32'h2801);
    wait_idle();
    rd("data_ch0", OFF_DATA, 32'h010);
    rd("data_ch2", OFF_DATA + 8'h08, 32'h211);
    chk("scan_end_count", 1, n_irq);
    chk("compare_count", 1, n_cmp);
    // eight-bit precision with clear after read
    wr(OFF_CONF, 32'h6);
    wr(OFF_CHAN_A, 32'h01);
    wr(OFF_CTRL, 32'h0801);
    wait_idle();
    rd("data_8bit", OFF_DATA, 32'h001);
    rd("data_cleared", OFF_DATA, 32'h000);
    wr(OFF_CONF, 32'h0);
    // double trigger on ch3, two software starts
    wr(OFF_CHAN_A, 32'h08);
    wr(OFF_CTRL, 32'h0B81);
    wait_idle();
    chk("dbl_first_irq", 2, n_irq);
    wr(OFF_CTRL, 32'h0B81);
    wait_idle();
    rd("dbl_data", OFF_DATA + 8'h0C, 32'h313);
    rd("dbl_dup", OFF_DUP, 32'h314);
    chk("dbl_irq", 3, n_irq);
    chk("dbl_events", 4, n_evt);
    // slow core: group B preempted by group A, then rescanned
    lat <= 8'd20;
    wr(OFF_CHAN_A, 32'h01);
    wr(OFF_CHAN_B, 32'h30);
    wr(OFF_TRIG, 32'hF0);
    wr(OFF_CTRL, 32'h186C);
    event_link_trig <= 1'b1;
    @(posedge mclk);
    event_link_trig <= 1'b0;
    repeat (8) @(posedge mclk);
    sync_trig[0] <= 1'b1;
    @(posedge mclk);
    sync_trig[0] <= 1'b0;
    wait_idle();
    chk("abort_count", 1, n_abort);
    rd("grp_a_data", OFF_DATA, 32'h015);
    rd("rescan_ch4", OFF_DATA + 8'h10, 32'h416);
    rd("rescan_ch5", OFF_DATA + 8'h14, 32'h517);
    chk("grp_a_irq", 4, n_irq);
    chk("grp_b_irq", 1, n_gb);
    chk("grp_events", 5, n_evt);
    chk("dma_count", 5, n_dma);
    // falling edge on the external pin
    wr(OFF_CTRL, 32'h0818);
    ext_n <= 1'b0;
    repeat (6) @(posedge mclk);
    ext_n <= 1'b1;
    wait_idle();
    rd("ext_data", OFF_DATA, 32'h018);
    chk("ext_irq", 5, n_irq);
    // ch0 averaged over four conversions, then the diagnostic slot, precharge on
    wr(OFF_CONF, 32'h0028_09B8);
    wr(OFF_CTRL, 32'h0801);
    wait_idle();
    chk("req_states", 32'h5, {24'h0, conv_req.sample_states});
    chk("req_precharge", 32'h1, {31'h0, conv_req.precharge});
    rd("avg_ch0", OFF_DATA, 32'h01A);
    rd("diag_data", OFF_DIAG, 32'h81D);
    chk("diag_irq", 6, n_irq);
    // module stop
    wr(OFF_CTRL, 32'h4000);
    repeat (2) @(posedge mclk);
    chk("stopped", 1, {31'h0, stopped});
    end_of_test();
  end
endmodule : adc_scan_trigger_control_bench
`default_nettype wire
